//--- rtl/wpc_pkg.sv
// Shared constants, types and helpers of the two-wire wiper control block
package wpc_pkg;

   // ---------------------------------------------------------------
   // Wiper register and instruction byte layout
   // ---------------------------------------------------------------
   localparam int          WIPER_W      = 8;
   localparam int          TAP_N        = 256;
   localparam logic [7:0]  MIDSCALE     = 8'h80;
   localparam int          INSTR_RS_BIT = 6;
   localparam int          INSTR_SD_BIT = 5;
   localparam logic [7:0]  TAP_B_CODE   = 8'h00;

   // ---------------------------------------------------------------
   // Bit counter positions within a nine-clock byte slot
   // ---------------------------------------------------------------
   localparam logic [3:0]  BIT_FIRST    = 4'h0;
   localparam logic [3:0]  BIT_LAST     = 4'h7;
   localparam logic [3:0]  BIT_ACK      = 4'h8;
   localparam logic [3:0]  BIT_STEP     = 4'h1;

   // ---------------------------------------------------------------
   // Synchroniser pin slots (scl, sda, address select, mode select)
   // ---------------------------------------------------------------
   localparam int          PIN_SCL      = 0;
   localparam int          PIN_SDA      = 1;
   localparam int          PIN_ADSEL    = 2;
   localparam int          PIN_ISEL     = 3;
   localparam logic [3:0]  PIN_RST      = 4'hb;

   // Clock line must be seen high this many cycles to trust framing
   localparam logic [1:0]  SCL_HOLD     = 2'h3;
   localparam logic [1:0]  HOLD_STEP    = 2'h1;

   // Link state, one-hot
   typedef enum logic [4:0] {
      WPC_ADDR  = 5'h01,
      WPC_INSTR = 5'h02,
      WPC_WDATA = 5'h04,
      WPC_RDATA = 5'h08,
      WPC_SKIP  = 5'h10
   } wpc_state_t;

   // One received write byte handed to the system domain
   typedef struct packed {
      logic       is_data;
      logic       rs;
      logic       sd;
      logic [7:0] data;
   } wpc_word_t;

   // Take the new value only once stages two and three agree
   function automatic logic [3:0] wpc_settle(input logic [3:0] s2,
                                             input logic [3:0] s3,
                                             input logic [3:0] q);
      wpc_settle = (s2 & s3) | (q & (s2 | s3));
   endfunction

endpackage

//--- rtl/wpc_tap_decoder.sv
// One-hot tap decoder for the 256-position resistor ladder
`timescale 1ns/1ns
`default_nettype none

module wpc_tap_decoder (
   input  wire logic                     clk,        // System clock
   input  wire logic                     resetn,     // Async reset, low
   input  wire logic [wpc_pkg::WIPER_W-1:0] code,    // Wiper register
   input  wire logic                     shutdown,   // Force tap B
   output logic [wpc_pkg::TAP_N-1:0]     tap_sel_r   // One-hot tap select
);

   logic [wpc_pkg::WIPER_W-1:0] eff_code;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   // Shutdown parks the wiper on B without touching the stored code
   assign eff_code = shutdown ? wpc_pkg::TAP_B_CODE : code;

   // Registered so the ladder switches never see decode glitches
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tap_sel_r <= '0;
         tap_sel_r[wpc_pkg::MIDSCALE] <= 1'b1;
      end else begin
         tap_sel_r <= '0;
         tap_sel_r[eff_code] <= 1'b1;
      end
   end

endmodule

`default_nettype wire

//--- rtl/wpc_top.sv
// Two-wire target logic and wiper register of the digital potentiometer
// Function
// - Answer address {device code, address select pin} plus a R/W bit.
// - A write carries address, instruction, data, each acknowledged.
// - A read sends the wiper byte right after the address acknowledge.
// - Further data bytes in one write update the wiper, same instruction.
// - Midscale reset bit high loads the wiper register with 80 hex.
// - Shutdown bit high ties the wiper to B and opens terminal A.
// - Shutdown keeps the stored code, which returns when it is cleared.
// - Bytes go MSB first; instruction bit 7 and bits 4..0 are ignored.
// - Power-up loads the wiper register with midscale.
// - The 8-bit wiper drives exactly one of 256 one-hot taps.
// - Code 00 selects tap B; each increment steps one tap toward A.
// - Mode select low means three-wire mode, high means two-wire mode.
`timescale 1ns/1ns
`default_nettype none

module wpc_top #(
   parameter logic [5:0] DEV_CODE = 6'h2a   // Arbitrary device code
) (
   input  wire logic         clk,                  // System clock 10 MHz
   input  wire logic         resetn,               // Power-on reset, low
   input  wire logic         scl_clk,              // Bus clock, link domain
   input  wire logic         sda_i,                // Data line level
   output logic              sda_o,                // Data drive value
   output logic              sda_oe,               // High pulls data low
   input  wire logic         address_select_pin,   // Address bit 0 strap
   input  wire logic         interface_select_pin, // High: two-wire mode
   output logic [255:0]      tap_sel,              // One-hot ladder tap
   output logic              terminal_a_open,      // A terminal open
   output logic              wiper_to_b,           // Wiper shorted to B
   output logic [7:0]        wiper_setting         // Stored wiper code
);

   // ---------------------------------------------------------------
   // System domain: pin synchronisers and bus framing
   // ---------------------------------------------------------------
   logic [3:0]            pin_s1_r, pin_s2_r, pin_s3_r;
   logic [3:0]            pin_q_r, pin_qd_r;
   logic                  idle_r;
   logic [1:0]            scl_hi_r;
   logic                  bus_start, bus_stop;
   logic                  link_rst_n;

   // Three-stage capture; only stage two reads stage one
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_s1_r <= wpc_pkg::PIN_RST;
         pin_s2_r <= wpc_pkg::PIN_RST;
         pin_s3_r <= wpc_pkg::PIN_RST;
         pin_q_r  <= wpc_pkg::PIN_RST;
         pin_qd_r <= wpc_pkg::PIN_RST;
      end else begin
         pin_s1_r <= {interface_select_pin, address_select_pin,
                      sda_i, scl_clk};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_q_r  <= wpc_pkg::wpc_settle(pin_s2_r, pin_s3_r, pin_q_r);
         pin_qd_r <= pin_q_r;
      end
   end

   // Clock high run length; a fast bus clock aliases into short highs
   // here, and data edges inside them would look like stops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scl_hi_r <= '0;
      end else if (!pin_q_r[wpc_pkg::PIN_SCL]) begin
         scl_hi_r <= '0;
      end else if (scl_hi_r != wpc_pkg::SCL_HOLD) begin
         scl_hi_r <= 2'(scl_hi_r + wpc_pkg::HOLD_STEP);
      end
   end

   // Start and stop seen while the clock line stays high
   assign bus_start = pin_q_r[wpc_pkg::PIN_SCL] &
                      pin_qd_r[wpc_pkg::PIN_SCL] &
                      (scl_hi_r == wpc_pkg::SCL_HOLD) &
                      pin_qd_r[wpc_pkg::PIN_SDA] &
                      !pin_q_r[wpc_pkg::PIN_SDA];
   assign bus_stop  = pin_q_r[wpc_pkg::PIN_SCL] &
                      pin_qd_r[wpc_pkg::PIN_SCL] &
                      (scl_hi_r == wpc_pkg::SCL_HOLD) &
                      !pin_qd_r[wpc_pkg::PIN_SDA] &
                      pin_q_r[wpc_pkg::PIN_SDA];

   // Idle holds the link logic in reset; the clock line cannot show a
   // stop, so the stop is caught here and ends the frame
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         idle_r <= 1'b1;
      end else if (!pin_q_r[wpc_pkg::PIN_ISEL] || bus_stop) begin
         idle_r <= 1'b1;
      end else if (bus_start) begin
         idle_r <= 1'b0;
      end
   end

   assign link_rst_n = !idle_r;

   // ---------------------------------------------------------------
   // Link domain: bit capture on the rising bus clock
   // ---------------------------------------------------------------
   wpc_pkg::wpc_state_t   state_r;
   logic [3:0]            bit_cnt_r;
   logic [7:0]            rx_r;
   logic [7:0]            tx_r;
   logic                  sda_pos_r;
   logic                  oe_r;
   logic [1:0]            instr_r;
   logic                  restart, byte_done, addr_hit;
   wpc_pkg::wpc_word_t    word_r;
   logic                  word_tog_r;

   // Data is stable while the clock is high; shift MSB first
   always_ff @(posedge scl_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sda_pos_r <= 1'b1;
         rx_r      <= '0;
      end else begin
         sda_pos_r <= sda_i;
         if (bit_cnt_r != wpc_pkg::BIT_ACK) begin
            rx_r <= {rx_r[6:0], sda_i};
         end
      end
   end

   // A fall of data between rising and falling clock is a repeated start
   assign restart   = sda_pos_r & !sda_i;
   assign byte_done = !restart && (bit_cnt_r == wpc_pkg::BIT_LAST);
   assign addr_hit  = (rx_r[7:1] ==
                       {DEV_CODE, pin_q_r[wpc_pkg::PIN_ADSEL]});

   // ---------------------------------------------------------------
   // Link domain: byte sequencing on the falling bus clock
   // ---------------------------------------------------------------
   // The wiper is read across domains without a handshake: it only
   // changes a few system cycles after a write byte, never inside a
   // read frame, so it is quiet whenever it is sampled here
   always_ff @(negedge scl_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         state_r   <= wpc_pkg::WPC_ADDR;
         bit_cnt_r <= wpc_pkg::BIT_FIRST;
         oe_r      <= 1'b0;
         tx_r      <= '0;
         instr_r   <= '0;
      end else if (restart) begin
         state_r   <= wpc_pkg::WPC_ADDR;
         bit_cnt_r <= wpc_pkg::BIT_FIRST;
         oe_r      <= 1'b0;
      end else if (byte_done) begin
         bit_cnt_r <= wpc_pkg::BIT_ACK;
         unique case (state_r)
            wpc_pkg::WPC_ADDR: begin
               if (addr_hit) begin
                  oe_r    <= 1'b1;
                  state_r <= rx_r[0] ? wpc_pkg::WPC_RDATA
                                     : wpc_pkg::WPC_INSTR;
               end else begin
                  state_r <= wpc_pkg::WPC_SKIP;
               end
            end
            wpc_pkg::WPC_INSTR: begin
               oe_r    <= 1'b1;
               instr_r <= {rx_r[wpc_pkg::INSTR_RS_BIT],
                           rx_r[wpc_pkg::INSTR_SD_BIT]};
               state_r <= wpc_pkg::WPC_WDATA;
            end
            wpc_pkg::WPC_WDATA: begin
               oe_r <= 1'b1;
            end
            wpc_pkg::WPC_RDATA: begin
               oe_r <= 1'b0;                    // Master drives its ack
            end
            wpc_pkg::WPC_SKIP: begin
               oe_r <= 1'b0;
            end
            default: begin
               state_r <= wpc_pkg::WPC_SKIP;
               oe_r    <= 1'b0;
            end
         endcase
      end else if (bit_cnt_r == wpc_pkg::BIT_ACK) begin
         bit_cnt_r <= wpc_pkg::BIT_FIRST;
         // Low on the ack slot: our own address ack or master ack
         if (state_r == wpc_pkg::WPC_RDATA && !sda_pos_r) begin
            tx_r <= wiper_setting;
            oe_r <= !wiper_setting[7];
         end else if (state_r == wpc_pkg::WPC_RDATA) begin
            state_r <= wpc_pkg::WPC_SKIP;       // Nack ends the read
            oe_r    <= 1'b0;
         end else begin
            oe_r <= 1'b0;
         end
      end else begin
         bit_cnt_r <= 4'(bit_cnt_r + wpc_pkg::BIT_STEP);
         if (state_r == wpc_pkg::WPC_RDATA) begin
            tx_r <= {tx_r[6:0], 1'b0};
            oe_r <= !tx_r[6];
         end
      end
   end

   // Each received instruction or data byte becomes one toggle event;
   // not cleared at a stop, which would fake one more event
   always_ff @(negedge scl_clk or negedge resetn) begin
      if (!resetn) begin
         word_r     <= '0;
         word_tog_r <= 1'b0;
      end else if (byte_done && state_r == wpc_pkg::WPC_INSTR) begin
         word_r     <= '{is_data: 1'b0,
                         rs: rx_r[wpc_pkg::INSTR_RS_BIT],
                         sd: rx_r[wpc_pkg::INSTR_SD_BIT],
                         data: rx_r};
         word_tog_r <= !word_tog_r;
      end else if (byte_done && state_r == wpc_pkg::WPC_WDATA) begin
         // Repeated data reuses the instruction of this frame
         word_r     <= '{is_data: 1'b1, rs: instr_r[1], sd: instr_r[0],
                         data: rx_r};
         word_tog_r <= !word_tog_r;
      end
   end

   // Open drain: the data value is always low, only the enable moves
   assign sda_o  = 1'b0;
   assign sda_oe = oe_r;

   // ---------------------------------------------------------------
   // System domain: write events and the wiper register
   // ---------------------------------------------------------------
   logic [2:0]            tog_s_r;
   logic                  tog_q_r;
   logic                  tog_seen_r;
   logic                  evt;
   logic [7:0]            wiper_r;
   logic                  shutdown_r;

   // Toggle crossing; the word is held steady for nine bus clocks
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tog_s_r    <= '0;
         tog_q_r    <= 1'b0;
         tog_seen_r <= 1'b0;
      end else begin
         tog_s_r    <= {tog_s_r[1:0], word_tog_r};
         if (tog_s_r[1] == tog_s_r[2]) begin
            tog_q_r <= tog_s_r[2];
         end
         tog_seen_r <= tog_q_r;
      end
   end

   assign evt = tog_q_r ^ tog_seen_r;

   // Midscale reset wins over the data byte that follows it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wiper_r <= wpc_pkg::MIDSCALE;
      end else if (evt && word_r.rs) begin
         wiper_r <= wpc_pkg::MIDSCALE;
      end else if (evt && word_r.is_data) begin
         wiper_r <= word_r.data;
      end
   end

   // Shutdown gates the decoder and drives the A open and wiper-to-B outputs; the stored code stays put
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shutdown_r <= 1'b0;
      end else if (evt) begin
         shutdown_r <= word_r.sd;
      end
   end

   assign wiper_setting   = wiper_r;
   assign terminal_a_open = shutdown_r;
   assign wiper_to_b      = shutdown_r;

   // ---------------------------------------------------------------
   // Ladder tap decoder
   // ---------------------------------------------------------------
   wpc_tap_decoder u_taps (
      .clk       (clk),
      .resetn    (resetn),
      .code      (wiper_r),
      .shutdown  (shutdown_r),
      .tap_sel_r (tap_sel)
   );

endmodule

`default_nettype wire

//--- verif/i2c_wiper_control_bench.sv
// Self-checking bench of the two-wire wiper control block
`timescale 1ns/1ns
`default_nettype none

module i2c_wiper_control_bench;
   localparam logic [5:0] DEV = 6'h15;  // Arbitrary device code
   typedef struct packed {
      logic [7:0] ins;
      logic [7:0] d;
      logic [7:0] w;
      logic       sd;
   } wpc_row_t;
   wpc_row_t rows [6] = '{'{8'h00, 8'h00, 8'h00, 1'b0},
      '{8'h9f, 8'h01, 8'h01, 1'b0}, '{8'h20, 8'h5a, 8'h5a, 1'b1},
      '{8'h00, 8'hff, 8'hff, 1'b0}, '{8'h40, 8'h33, 8'h80, 1'b0},
      '{8'h60, 8'h12, 8'h80, 1'b1}};
   logic         clk, resetn, adsel, isel, sda_oe, sda_o, scl, pull;
   logic         a_open, to_b, ack;
   logic [255:0] tap_sel;
   logic [7:0]   wiper, rd, adr;
   wire logic    sda;
   int           n_mismatch, tests_run;

   // Open drain wire with pull-up
   assign sda = ~pull & (~sda_oe | sda_o);

   wpc_top #(.DEV_CODE(DEV)) dut_u (.clk(clk), .resetn(resetn),
      .scl_clk(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .address_select_pin(adsel), .interface_select_pin(isel),
      .tap_sel(tap_sel), .terminal_a_open(a_open), .wiper_to_b(to_b),
      .wiper_setting(wiper));
   wpc_bus_master mst_u (.scl(scl), .sda_pull(pull), .sda(sda));

   // ---------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [255:0] got, input logic [255:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   // Bounded wait for the update, then outputs one clock later
   task automatic settle(input logic [7:0] w, input logic sd);
      int i;
      i = 0;
      while (i < 40 && !(wiper === w && to_b === sd)) begin
         @(posedge clk) #1;
         i++;
      end
      if (i == 40) begin
         n_mismatch++;
         $display("wrong value t=%0t no update", $time);
         final_report();
      end
      @(posedge clk) #1;
      check(wiper, w);
      check(a_open, sd);
      check(tap_sel, 256'h1 << (sd ? 0 : w));
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] ins,
                     input logic [7:0] d, output logic ok);
      logic x;
      mst_u.start_cond();
      mst_u.put_byte(a, ok);
      if (ok) begin
         mst_u.put_byte(ins, x);
         mst_u.put_byte(d, x);
      end
      mst_u.stop_cond();
   endtask

   task automatic rdb(input logic [7:0] a, output logic [7:0] d);
      mst_u.start_cond();
      mst_u.put_byte(a | 8'h01, ack);
      mst_u.get_byte(1'b0, d);
      mst_u.stop_cond();
   endtask

   // ---------------------------------------------------------
   // Clock, watchdog and main sequence
   // ---------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      #2000000;
      n_mismatch++;
      final_report();
   end

   initial begin
      resetn = 1'b0;
      adsel = 1'b0;
      isel = 1'b1;
      adr = {DEV, 1'b0, 1'b0};
      repeat (8) @(posedge clk);
      #5 resetn = 1'b1;
      settle(8'h80, 1'b0);
      $display("power-on preset done");
      foreach (rows[k]) begin
         wr(adr, rows[k].ins, rows[k].d, ack);
         check(ack, 1'b1);
         settle(rows[k].w, rows[k].sd);
         rdb(adr, rd);
         check(rd, rows[k].w);
         $display("row %0d done", k);
      end
      // Wrong address bit: ignored, nothing changes
      wr({DEV, 1'b1, 1'b0}, 8'h00, 8'h11, ack);
      check(ack, 1'b0);
      settle(8'h80, 1'b1);
      $display("address mismatch done");
      @(posedge clk) #5 adsel = 1'b1;
      adr = {DEV, 1'b1, 1'b0};
      repeat (6) @(posedge clk);
      wr(adr, 8'h00, 8'hc3, ack);
      check(ack, 1'b1);
      settle(8'hc3, 1'b0);
      $display("address strap done");
      // Two data bytes under one shutdown instruction
      mst_u.start_cond();
      mst_u.put_byte(adr, ack);
      mst_u.put_byte(8'h20, ack);
      mst_u.put_byte(8'h11, ack);
      settle(8'h11, 1'b1);
      mst_u.put_byte(8'h22, ack);
      check(ack, 1'b1);
      settle(8'h22, 1'b1);
      mst_u.stop_cond();
      $display("repeated write done");
      mst_u.start_cond();
      mst_u.put_byte(adr | 8'h01, ack);
      mst_u.get_byte(1'b1, rd);
      check(rd, 8'h22);
      mst_u.get_byte(1'b0, rd);
      check(rd, 8'h22);
      mst_u.stop_cond();
      $display("repeated read done");
      // Three-wire mode: bus traffic is ignored
      @(posedge clk) #5 isel = 1'b0;
      repeat (8) @(posedge clk);
      wr(adr, 8'h00, 8'h44, ack);
      check(ack, 1'b0);
      settle(8'h22, 1'b1);
      @(posedge clk) #5 isel = 1'b1;
      $display("mode select done");
      // Reset again in mid-run: the preset must come back
      @(posedge clk) #5 resetn = 1'b0;
      repeat (2) @(posedge clk);
      #5 resetn = 1'b1;
      settle(8'h80, 1'b0);
      $display("mid-run reset done");
      final_report();
   end
endmodule
`default_nettype wire

//--- verif/wpc_bus_master.sv
// Two-wire bus master model: clock line, data pull-down, byte tasks
`timescale 1ns/1ns
`default_nettype none

module wpc_bus_master (
   output logic     scl,      // Bus clock, high between frames
   output logic     sda_pull, // High pulls data low
   input wire logic sda       // Resolved data wire
);
   // ---------------------------------------------------------
   // Frame tasks, 80 ns bit period
   // ---------------------------------------------------------
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // Long clock high so the system domain sees the start
   task automatic start_cond();
      #700 sda_pull = 1'b1;
      #700 scl = 1'b0;
   endtask

   // Stop, then bus idle long enough before any next start
   task automatic stop_cond();
      #20 sda_pull = 1'b1;
      #20 scl = 1'b1;
      #700 sda_pull = 1'b0;
      #700;
   endtask

   // Data moves only while the clock is low
   task automatic clk_bit(input logic b, output logic r);
      #20 sda_pull = ~b;
      #20 scl = 1'b1;
      #20 r = sda;
      #20 scl = 1'b0;
   endtask

   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
      clk_bit(1'b1, r);
      ack = ~r;
   endtask

   // Master acknowledge asks for another byte
   task automatic get_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(~more, r);
   endtask
endmodule
`default_nettype wire

//--- verif/wpc_monitor.sv
// Concurrent checks on the ports of the wiper control top level
`timescale 1ns/1ns
`default_nettype none

module wpc_monitor #(
   parameter logic [5:0] DEV_CODE = 6'h2a   // Arbitrary device code
) (
   input wire logic         clk,                  // System clock
   input wire logic         resetn,               // Async reset, low
   input wire logic         scl_clk,              // Bus clock
   input wire logic         sda_i,                // Data wire level
   input wire logic         sda_o,                // Data drive value
   input wire logic         sda_oe,               // Data pull enable
   input wire logic         address_select_pin,   // Address strap
   input wire logic         interface_select_pin, // Mode select
   input wire logic [255:0] tap_sel,              // One-hot tap
   input wire logic         terminal_a_open,      // A terminal open
   input wire logic         wiper_to_b,           // Wiper on B
   input wire logic [7:0]   wiper_setting         // Stored code
);
   // ---------------------------------------------------------
   // Properties, all in the system clock domain
   // ---------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_reset_preset: assert property ($rose(resetn) |->
      wiper_setting == 8'h80 && tap_sel == 256'h1 << 128 && !sda_oe)
      else $error("preset wrong after reset");
   a_tap_onehot: assert property ($onehot(tap_sel))
      else $error("tap select not one-hot");
   // Tap lags the code by a cycle, so only judge settled codes
   a_tap_code: assert property (!wiper_to_b && $stable(wiper_to_b)
      && $stable(wiper_setting) |-> tap_sel == 256'h1 << wiper_setting)
      else $error("tap select does not match code");
   a_shut_tap_b: assert property (wiper_to_b && $past(wiper_to_b)
      |-> tap_sel == 256'h1)
      else $error("shutdown tap not at B");
   a_shut_pair: assert property (terminal_a_open == wiper_to_b)
      else $error("A terminal and wiper short disagree");
   // A midscale load may coincide with a shutdown change
   a_shut_keeps: assert property ($changed(wiper_to_b)
      && wiper_setting != 8'h80 |-> $stable(wiper_setting))
      else $error("shutdown change disturbed wiper code");
   a_mode_quiet: assert property (!interface_select_pin [*8]
      |-> !sda_oe)
      else $error("data driven in three-wire mode");
   a_mode_hold: assert property (!interface_select_pin [*8]
      |=> $stable(wiper_setting))
      else $error("wiper changed in three-wire mode");

   c_shutdown: cover property ($rose(wiper_to_b));
   c_full: cover property (wiper_setting == 8'hff);
   c_ack: cover property ($rose(sda_oe));
endmodule

bind wpc_top wpc_monitor #(.DEV_CODE(DEV_CODE)) mon_u (
   .clk(clk), .resetn(resetn), .scl_clk(scl_clk), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .address_select_pin(address_select_pin),
   .interface_select_pin(interface_select_pin), .tap_sel(tap_sel),
   .terminal_a_open(terminal_a_open), .wiper_to_b(wiper_to_b),
   .wiper_setting(wiper_setting));
`default_nettype wire
